// >>> hw/papom_port_a_mux.sv
// Port A alternate-function override mux, eight pins
// What this block does
// - Three-wire shifter output replaces pin 2 value; driven only if dir set.
// - Pin 2 as shifter output but input: port bit still enables pull-up.
// - SPI master forces pin 2 to input.
// - SPI slave leaves pin 2 direction to its direction bit.
// - While SPI forces pin 2 input, port bit still controls pull-up.
// - UART transmitter forces pin 1 to output.
// - LIN forces pin 1 to output carrying the LIN transmit line.
// - UART receiver forces pin 0 to input.
// - Pin 0 forced input: port bit one turns on pull-up.
// - LIN forces pin 0 to input for the LIN receive line.
// - Pin 1 pull-up value zero while transmitting, else port and not-disable.
// - Pin 7 no overrides; input enable from analog-off or pin-change.
// - Pins 3..0 input enable likewise; pin 3 also by ext interrupt 1.
// - Each pin merges override pairs that beat the port register bits.
// - Global pull-up disable turns off every pull-up.
// - Port-wise pull-up disable ORed with global disable.
// - SPI slave forces pin 6 slave select to input.
`timescale 1ns/10ps
`include "papom_params.svh"
module papom_port_a_mux (
    input  wire logic       REF_CLK,
    input  wire logic       RST_B,
    input  wire logic [7:0] DIR_BITS,
    input  wire logic [7:0] OUT_BITS,
    input  wire logic       GLOBAL_PULLUP_OFF,
    input  wire logic [1:0] PORTWISE_PULLUP_OFF,
    input  wire logic       SPI_ON,
    input  wire logic       SPI_MASTER_SEL,
    input  wire logic       SPI_MISO_OUT,
    input  wire logic       SPI_SCK_OUT,
    input  wire logic       SPI_MOSI_OUT,
    input  wire logic       SHIFTER_PIN_POSITION_SEL,
    input  wire logic       SHIFTER_THREE_WIRE_MODE,
    input  wire logic       SHIFTER_MSB_OUT,
    input  wire logic       SHIFTER_TOGGLE_REQ,
    input  wire logic       TIMER0_MATCH_A_EN,
    input  wire logic       TIMER0_MATCH_A_OUT,
    input  wire logic       UART_TX_ON,
    input  wire logic       UART_TX_DATA,
    input  wire logic       UART_RX_ON,
    input  wire logic       LIN_ON,
    input  wire logic       LIN_TX_LINE,
    input  wire logic       PINCHANGE_GROUP0_ON,
    input  wire logic [7:0] PINCHANGE_MASK_BITS,
    input  wire logic [7:0] ANALOG_DIGITAL_INPUT_OFF,
    input  wire logic       EXT_IRQ1_ON,
    input  wire logic [7:0] PAD_IN,
    output logic      [7:0] PULLUP_OVERRIDE_EN,
    output logic      [7:0] PULLUP_OVERRIDE_VAL,
    output logic      [7:0] DIRECTION_OVERRIDE_EN,
    output logic      [7:0] DIRECTION_OVERRIDE_VAL,
    output logic      [7:0] PORTVALUE_OVERRIDE_EN,
    output logic      [7:0] PORTVALUE_OVERRIDE_VAL,
    output logic      [7:0] TOGGLE_OVERRIDE_EN,
    output logic      [7:0] INPUT_ENABLE_OVERRIDE_EN,
    output logic      [7:0] INPUT_ENABLE_OVERRIDE_VAL,
    output logic      [7:0] PULLUP_EN,
    output logic      [7:0] OUT_EN_B,
    output logic      [7:0] OUT_VAL,
    output logic      [7:0] DIN_EN,
    output logic      [7:0] PIN_VAL,
    output logic            LIN_RX_LINE
);
    papom_pkg::papom_state_type state_q;
    papom_pkg::papom_state_type state_d;

    logic pud_eff;
    logic spi_master;
    logic spi_slave;
    logic shifter_out_on;
    logic tx_force;
    logic rx_force;
    logic uart_tx_only;

    // Pin-change term that both gates and enables an input buffer
    function automatic logic pc_hit(input logic grp_on,
                                    input logic mask_bit);
        pc_hit = grp_on & mask_bit;
    endfunction

    // Not-disabled port bit, feeds the pull-up override values of pins 0, 1, 2, 4, 5 and 6
    function automatic logic pu_keep(input logic out_bit,
                                     input logic global_pullup_off);
        pu_keep = out_bit & ~global_pullup_off;
    endfunction

    assign pud_eff = GLOBAL_PULLUP_OFF
                   | PORTWISE_PULLUP_OFF[`PAPOM_PORT_BIT];
    assign spi_master     = SPI_ON & SPI_MASTER_SEL;
    assign spi_slave      = SPI_ON & ~SPI_MASTER_SEL;
    assign shifter_out_on = SHIFTER_THREE_WIRE_MODE
                          & SHIFTER_PIN_POSITION_SEL;
    assign tx_force       = LIN_ON | UART_TX_ON;
    assign rx_force       = LIN_ON | UART_RX_ON;
    // LIN owns pin 1 when both transmitters are on
    assign uart_tx_only   = UART_TX_ON & ~LIN_ON;

    always_comb begin
        PULLUP_OVERRIDE_EN        = `PAPOM_NONE;
        PULLUP_OVERRIDE_VAL       = `PAPOM_NONE;
        DIRECTION_OVERRIDE_EN     = `PAPOM_NONE;
        DIRECTION_OVERRIDE_VAL    = `PAPOM_NONE;
        PORTVALUE_OVERRIDE_EN     = `PAPOM_NONE;
        PORTVALUE_OVERRIDE_VAL    = `PAPOM_NONE;
        TOGGLE_OVERRIDE_EN        = `PAPOM_NONE;
        INPUT_ENABLE_OVERRIDE_EN  = `PAPOM_NONE;
        INPUT_ENABLE_OVERRIDE_VAL = `PAPOM_NONE;

        // Pin 7: analog only, no drive overrides
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_REF] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_REF]
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_REF]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_REF] =
            pc_hit(PINCHANGE_GROUP0_ON,
                   PINCHANGE_MASK_BITS[`PAPOM_PIN_REF]);

        // Pin 6: slave select is an input in slave role
        PULLUP_OVERRIDE_EN[`PAPOM_PIN_SS]    = spi_slave;
        PULLUP_OVERRIDE_VAL[`PAPOM_PIN_SS]   =
            pu_keep(OUT_BITS[`PAPOM_PIN_SS], pud_eff);
        DIRECTION_OVERRIDE_EN[`PAPOM_PIN_SS] = spi_slave;
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_SS] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_SS]
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_SS]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_SS] =
            pc_hit(PINCHANGE_GROUP0_ON,
                   PINCHANGE_MASK_BITS[`PAPOM_PIN_SS]);

        // Pins 5 and 4: SPI clock and master data
        PULLUP_OVERRIDE_EN[`PAPOM_PIN_SCK]     = spi_slave;
        PULLUP_OVERRIDE_VAL[`PAPOM_PIN_SCK]    =
            pu_keep(OUT_BITS[`PAPOM_PIN_SCK], pud_eff);
        DIRECTION_OVERRIDE_EN[`PAPOM_PIN_SCK]  = spi_slave;
        PORTVALUE_OVERRIDE_EN[`PAPOM_PIN_SCK]  = spi_master;
        PORTVALUE_OVERRIDE_VAL[`PAPOM_PIN_SCK] = SPI_SCK_OUT;
        TOGGLE_OVERRIDE_EN[`PAPOM_PIN_SCK]     =
            SHIFTER_TOGGLE_REQ & SHIFTER_PIN_POSITION_SEL;
        PULLUP_OVERRIDE_EN[`PAPOM_PIN_MOSI]     = spi_slave;
        PULLUP_OVERRIDE_VAL[`PAPOM_PIN_MOSI]    =
            pu_keep(OUT_BITS[`PAPOM_PIN_MOSI], pud_eff);
        DIRECTION_OVERRIDE_EN[`PAPOM_PIN_MOSI]  = spi_slave;
        PORTVALUE_OVERRIDE_EN[`PAPOM_PIN_MOSI]  = spi_master;
        PORTVALUE_OVERRIDE_VAL[`PAPOM_PIN_MOSI] = SPI_MOSI_OUT;
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_SCK] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_SCK]
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_SCK]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_SCK] =
            pc_hit(PINCHANGE_GROUP0_ON,
                   PINCHANGE_MASK_BITS[`PAPOM_PIN_SCK]);
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_MOSI] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_MOSI]
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_MOSI]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_MOSI] =
            pc_hit(PINCHANGE_GROUP0_ON,
                   PINCHANGE_MASK_BITS[`PAPOM_PIN_MOSI]);

        // Pin 3: external interrupt 1 keeps the buffer alive
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_IRQ1] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_IRQ1] | EXT_IRQ1_ON
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_IRQ1]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_IRQ1] = EXT_IRQ1_ON
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_IRQ1]);

        // Pin 2: master input, shifter or timer output
        PULLUP_OVERRIDE_EN[`PAPOM_PIN_SER]    = spi_master;
        PULLUP_OVERRIDE_VAL[`PAPOM_PIN_SER]   =
            pu_keep(OUT_BITS[`PAPOM_PIN_SER], pud_eff);
        // Slave role leaves direction to the direction bit
        DIRECTION_OVERRIDE_EN[`PAPOM_PIN_SER] = spi_master;
        // Shifter and timer only set the value; the pin drives
        // only once software has set the direction bit
        PORTVALUE_OVERRIDE_EN[`PAPOM_PIN_SER] = spi_master
            | shifter_out_on | TIMER0_MATCH_A_EN;
        if (spi_master) begin
            PORTVALUE_OVERRIDE_VAL[`PAPOM_PIN_SER] = SPI_MISO_OUT;
        end else if (shifter_out_on) begin
            PORTVALUE_OVERRIDE_VAL[`PAPOM_PIN_SER] =
                SHIFTER_MSB_OUT;
        end else begin
            PORTVALUE_OVERRIDE_VAL[`PAPOM_PIN_SER] =
                TIMER0_MATCH_A_OUT;
        end
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_SER] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_SER]
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_SER]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_SER] =
            pc_hit(PINCHANGE_GROUP0_ON,
                   PINCHANGE_MASK_BITS[`PAPOM_PIN_SER]);

        // Pin 1: UART or LIN transmit
        PULLUP_OVERRIDE_EN[`PAPOM_PIN_TX]     = tx_force;
        PULLUP_OVERRIDE_VAL[`PAPOM_PIN_TX]    = tx_force ? 1'b0
            : pu_keep(OUT_BITS[`PAPOM_PIN_TX], pud_eff);
        DIRECTION_OVERRIDE_EN[`PAPOM_PIN_TX]  = tx_force;
        DIRECTION_OVERRIDE_VAL[`PAPOM_PIN_TX] = tx_force;
        PORTVALUE_OVERRIDE_EN[`PAPOM_PIN_TX]  = tx_force;
        PORTVALUE_OVERRIDE_VAL[`PAPOM_PIN_TX] =
            uart_tx_only ? UART_TX_DATA : LIN_TX_LINE;
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_TX] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_TX]
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_TX]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_TX] =
            pc_hit(PINCHANGE_GROUP0_ON,
                   PINCHANGE_MASK_BITS[`PAPOM_PIN_TX]);

        // Pin 0: UART or LIN receive
        PULLUP_OVERRIDE_EN[`PAPOM_PIN_RX]     = rx_force;
        PULLUP_OVERRIDE_VAL[`PAPOM_PIN_RX]    =
            pu_keep(OUT_BITS[`PAPOM_PIN_RX], pud_eff);
        DIRECTION_OVERRIDE_EN[`PAPOM_PIN_RX]  = rx_force;
        INPUT_ENABLE_OVERRIDE_EN[`PAPOM_PIN_RX] =
            ANALOG_DIGITAL_INPUT_OFF[`PAPOM_PIN_RX]
            | pc_hit(PINCHANGE_GROUP0_ON,
                     PINCHANGE_MASK_BITS[`PAPOM_PIN_RX]);
        INPUT_ENABLE_OVERRIDE_VAL[`PAPOM_PIN_RX] =
            pc_hit(PINCHANGE_GROUP0_ON,
                   PINCHANGE_MASK_BITS[`PAPOM_PIN_RX]);

        // Pin readback samples only through an enabled buffer
        state_d        = state_q;
        state_d.pin_in = PAD_IN & DIN_EN;
    end

    for (genvar i = 0; i < 8; i++) begin : g_pin
        papom_pin_resolve u_pin (
            .pud_eff   (pud_eff),
            .dir_bit   (DIR_BITS[i]),
            .out_bit   (OUT_BITS[i]),
            .pu_oe     (PULLUP_OVERRIDE_EN[i]),
            .pu_ov     (PULLUP_OVERRIDE_VAL[i]),
            .dd_oe     (DIRECTION_OVERRIDE_EN[i]),
            .dd_ov     (DIRECTION_OVERRIDE_VAL[i]),
            .pv_oe     (PORTVALUE_OVERRIDE_EN[i]),
            .pv_ov     (PORTVALUE_OVERRIDE_VAL[i]),
            .die_oe    (INPUT_ENABLE_OVERRIDE_EN[i]),
            .die_ov    (INPUT_ENABLE_OVERRIDE_VAL[i]),
            .pullup_en (PULLUP_EN[i]),
            .out_en_b  (OUT_EN_B[i]),
            .out_val   (OUT_VAL[i]),
            .din_en    (DIN_EN[i])
        );
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            state_q.pin_in <= `PAPOM_PIN_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign PIN_VAL     = state_q.pin_in;
    assign LIN_RX_LINE = state_q.pin_in[`PAPOM_PIN_RX];
endmodule

// >>> inc/papom_params.svh
// Pin positions and reset values for the Port A override mux
`ifndef PAPOM_PARAMS_SVH
`define PAPOM_PARAMS_SVH
`define PAPOM_PIN_RX     0
`define PAPOM_PIN_TX     1
`define PAPOM_PIN_SER    2
`define PAPOM_PIN_IRQ1   3
`define PAPOM_PIN_MOSI   4
`define PAPOM_PIN_SCK    5
`define PAPOM_PIN_SS     6
`define PAPOM_PIN_REF    7
`define PAPOM_PORT_BIT   0
`define PAPOM_PIN_RST    8'h00
`define PAPOM_NONE       8'h00
`endif

// >>> inc/papom_pkg.sv
// Types shared by the Port A override mux
package papom_pkg;
    typedef logic [7:0] papom_byte_type;
    typedef struct packed {
        papom_byte_type pin_in;
    } papom_state_type;
endpackage

// >>> hw/papom_pin_resolve.sv
// One pin: applies override pairs over the port register bits
`timescale 1ns/10ps
module papom_pin_resolve (
    input  wire logic pud_eff,
    input  wire logic dir_bit,
    input  wire logic out_bit,
    input  wire logic pu_oe,
    input  wire logic pu_ov,
    input  wire logic dd_oe,
    input  wire logic dd_ov,
    input  wire logic pv_oe,
    input  wire logic pv_ov,
    input  wire logic die_oe,
    input  wire logic die_ov,
    output logic      pullup_en,
    output logic      out_en_b,
    output logic      out_val,
    output logic      din_en
);
    logic dir_eff;

    // Pure gates: an override acts in the same cycle
    assign dir_eff   = dd_oe ? dd_ov : dir_bit;
    assign pullup_en = pu_oe ? pu_ov
                             : (~dir_eff & out_bit & ~pud_eff);
    assign out_val   = pv_oe ? pv_ov : out_bit;
    assign out_en_b  = ~dir_eff;
    assign din_en    = die_oe ? die_ov : 1'b1;
endmodule

// >>> tb/papom_periph_model.sv
// Behavioural peripheral controllers that claim Port A pins
`timescale 1ns/10ps
module papom_periph_model (
    input  wire logic [2:0] mode,
    input  wire logic       d,
    output logic            spi_on,
    output logic            spi_master,
    output logic            shift_pos,
    output logic            shift_three,
    output logic            tmr_en,
    output logic            uart_tx,
    output logic            uart_rx,
    output logic            lin_on,
    output logic            nd
);
    // Modes: 0 idle, 1 uart, 2 lin, 3 spi master, 4 spi slave,
    // 5 shifter and timer, 6 timer, 7 spi master with shifter and timer
    always_comb begin
        spi_on      = mode inside {3'h3, 3'h4, 3'h7};
        spi_master  = mode inside {3'h3, 3'h7};
        shift_pos   = mode inside {3'h5, 3'h7};
        shift_three = mode inside {3'h5, 3'h7};
        tmr_en      = mode inside {3'h5, 3'h6, 3'h7};
        uart_tx     = mode == 3'h1;
        uart_rx     = mode == 3'h1;
        lin_on      = mode == 3'h2;
        // Shifter data opposite the rest so a wrong priority shows
        nd          = ~d;
    end
endmodule

// >>> tb/papom_assertions.sv
// Checker on the Port A override mux ports
`timescale 1ns/10ps
module papom_checker (
    input wire logic       REF_CLK,
    input wire logic       RST_B,
    input wire logic [7:0] DIR_BITS,
    input wire logic [7:0] OUT_BITS,
    input wire logic       GLOBAL_PULLUP_OFF,
    input wire logic [1:0] PORTWISE_PULLUP_OFF,
    input wire logic       SPI_ON,
    input wire logic       SPI_MASTER_SEL,
    input wire logic       SPI_MISO_OUT,
    input wire logic       SHIFTER_PIN_POSITION_SEL,
    input wire logic       SHIFTER_THREE_WIRE_MODE,
    input wire logic       SHIFTER_MSB_OUT,
    input wire logic       UART_TX_ON,
    input wire logic       UART_RX_ON,
    input wire logic       LIN_ON,
    input wire logic       LIN_TX_LINE,
    input wire logic       PINCHANGE_GROUP0_ON,
    input wire logic [7:0] PINCHANGE_MASK_BITS,
    input wire logic [7:0] ANALOG_DIGITAL_INPUT_OFF,
    input wire logic       EXT_IRQ1_ON,
    input wire logic [7:0] PAD_IN,
    input wire logic [7:0] PULLUP_OVERRIDE_EN,
    input wire logic [7:0] DIRECTION_OVERRIDE_EN,
    input wire logic [7:0] PORTVALUE_OVERRIDE_EN,
    input wire logic [7:0] PORTVALUE_OVERRIDE_VAL,
    input wire logic [7:0] INPUT_ENABLE_OVERRIDE_EN,
    input wire logic [7:0] PULLUP_EN,
    input wire logic [7:0] OUT_EN_B,
    input wire logic [7:0] OUT_VAL,
    input wire logic [7:0] DIN_EN,
    input wire logic [7:0] PIN_VAL,
    input wire logic       LIN_RX_LINE
);
    logic       global_pullup_off;
    logic [3:0] die_exp;
    assign global_pullup_off = GLOBAL_PULLUP_OFF | PORTWISE_PULLUP_OFF[0];
    assign die_exp = ANALOG_DIGITAL_INPUT_OFF[3:0] | {EXT_IRQ1_ON, 3'h0}
        | ({4{PINCHANGE_GROUP0_ON}} & PINCHANGE_MASK_BITS[3:0]);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_tx_force; UART_TX_ON || LIN_ON; endsequence
    sequence s_rx_force; UART_RX_ON || LIN_ON; endsequence
    sequence s_taken; RST_B; endsequence
    property p_tx_out; s_tx_force |-> !OUT_EN_B[1] && !PULLUP_EN[1]; endproperty
    a_tx_out: assert property (p_tx_out) else $error("pin 1 not output");
    property p_lin_val; LIN_ON |-> OUT_VAL[1] == LIN_TX_LINE; endproperty
    a_lin_val: assert property (p_lin_val) else $error("pin 1 value");
    property p_rx_in;
        s_rx_force |-> OUT_EN_B[0] && PULLUP_EN[0] == (OUT_BITS[0] && !global_pullup_off);
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("pin 0 not input");
    property p_spi_m;
        SPI_ON && SPI_MASTER_SEL |-> OUT_EN_B[2] && PULLUP_EN[2] ==
            (OUT_BITS[2] && !global_pullup_off) && PORTVALUE_OVERRIDE_VAL[2] == SPI_MISO_OUT;
    endproperty
    a_spi_m: assert property (p_spi_m) else $error("spi master pin 2");
    property p_spi_s;
        SPI_ON && !SPI_MASTER_SEL |-> OUT_EN_B[6] && OUT_EN_B[2] == !DIR_BITS[2];
    endproperty
    a_spi_s: assert property (p_spi_s) else $error("spi slave pins");
    property p_shift;
        SHIFTER_THREE_WIRE_MODE && SHIFTER_PIN_POSITION_SEL && !SPI_ON |->
            OUT_VAL[2] == SHIFTER_MSB_OUT && OUT_EN_B[2] == !DIR_BITS[2] &&
            (DIR_BITS[2] || PULLUP_EN[2] == (OUT_BITS[2] && !global_pullup_off));
    endproperty
    a_shift: assert property (p_shift) else $error("shifter pin 2");
    property p_pud; global_pullup_off |-> PULLUP_EN == 8'h00; endproperty
    a_pud: assert property (p_pud) else $error("pull-up while off");
    property p_pin7;
        !(PULLUP_OVERRIDE_EN[7] || DIRECTION_OVERRIDE_EN[7]
          || PORTVALUE_OVERRIDE_EN[7]) && INPUT_ENABLE_OVERRIDE_EN[7] ==
          (ANALOG_DIGITAL_INPUT_OFF[7] || PINCHANGE_GROUP0_ON
           && PINCHANGE_MASK_BITS[7]);
    endproperty
    a_pin7: assert property (p_pin7) else $error("pin 7 overrides");
    property p_die; INPUT_ENABLE_OVERRIDE_EN[3:0] == die_exp; endproperty
    a_die: assert property (p_die) else $error("input enable pins 3-0");
    property p_read;
        s_taken |=> PIN_VAL == ($past(PAD_IN) & $past(DIN_EN)) &&
            LIN_RX_LINE == PIN_VAL[0];
    endproperty
    a_read: assert property (p_read) else $error("pin readback");
    property p_rst;
        disable iff (1'b0) !RST_B |=> PIN_VAL == 8'h00 && !LIN_RX_LINE;
    endproperty
    a_rst: assert property (p_rst) else $error("readback not cleared");
endmodule
bind papom_port_a_mux papom_checker i_chk (.*);

// >>> tb/tb_port_a_pin_override_mux.sv
// Self-checking bench for the Port A override mux
`timescale 1ns/10ps
module tb_port_a_pin_override_mux;
    typedef struct packed {
        logic [2:0] mode;
        logic [7:0] dir;
        logic       global_pullup_off;
        logic       d;
        logic [7:0] oeb;
        logic [7:0] val;
        logic [7:0] pu;
    } papom_row_type;
    logic          ref_clk = 1'b0;
    logic          rst_b = 1'b0;
    logic [2:0]    mode = 3'h0;
    logic          d = 1'b0;
    logic [7:0]    dir = 8'h00;
    logic          gpud = 1'b0;
    logic [1:0]    ppud = 2'h0;
    logic          pcg = 1'b0;
    logic [7:0]    mask = 8'h00;
    logic [7:0]    ado = 8'h00;
    logic          irq1 = 1'b0;
    logic [7:0]    pad = 8'h00;
    logic          spi_on, spi_m, pos, three, tmr, utx, urx, lin, nd, lrx;
    logic [7:0]    pu_oe, dd_oe, pv_oe, pv_ov, die_oe, die_ov, pu_en, oe_b;
    logic [7:0]    o_val, pin_val;
    logic [7:0]    pu_ov, dd_ov, to_en, din;
    // Port bits vary so pull-up terms are not stuck at one
    logic [7:0]    obits = 8'h07;
    int            fail_count = 0;
    int            checks_done = 0;
    papom_row_type rows [10];
    always #4 ref_clk = ~ref_clk;
    papom_periph_model i_peri (.mode(mode), .d(d), .spi_on(spi_on),
        .spi_master(spi_m), .shift_pos(pos), .shift_three(three),
        .tmr_en(tmr), .uart_tx(utx), .uart_rx(urx), .lin_on(lin), .nd(nd));
    papom_port_a_mux i_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .DIR_BITS(dir),
        .OUT_BITS(obits), .GLOBAL_PULLUP_OFF(gpud), .PORTWISE_PULLUP_OFF(ppud),
        .SPI_ON(spi_on), .SPI_MASTER_SEL(spi_m), .SPI_MISO_OUT(d),
        .SPI_SCK_OUT(d), .SPI_MOSI_OUT(d), .SHIFTER_PIN_POSITION_SEL(pos),
        .SHIFTER_THREE_WIRE_MODE(three), .SHIFTER_MSB_OUT(nd),
        .SHIFTER_TOGGLE_REQ(d), .TIMER0_MATCH_A_EN(tmr),
        .TIMER0_MATCH_A_OUT(d), .UART_TX_ON(utx), .UART_TX_DATA(d),
        .UART_RX_ON(urx), .LIN_ON(lin), .LIN_TX_LINE(d),
        .PINCHANGE_GROUP0_ON(pcg), .PINCHANGE_MASK_BITS(mask),
        .ANALOG_DIGITAL_INPUT_OFF(ado), .EXT_IRQ1_ON(irq1), .PAD_IN(pad),
        .PULLUP_OVERRIDE_EN(pu_oe), .PULLUP_OVERRIDE_VAL(pu_ov),
        .DIRECTION_OVERRIDE_EN(dd_oe), .DIRECTION_OVERRIDE_VAL(dd_ov),
        .PORTVALUE_OVERRIDE_EN(pv_oe), .PORTVALUE_OVERRIDE_VAL(pv_ov),
        .TOGGLE_OVERRIDE_EN(to_en), .INPUT_ENABLE_OVERRIDE_EN(die_oe),
        .INPUT_ENABLE_OVERRIDE_VAL(die_ov), .PULLUP_EN(pu_en),
        .OUT_EN_B(oe_b), .OUT_VAL(o_val), .DIN_EN(din), .PIN_VAL(pin_val),
        .LIN_RX_LINE(lrx));
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        rows = '{'{3'h0, 8'h00, 1'b0, 1'b1, 8'h47, 8'h07, 8'h07},
                 '{3'h1, 8'h01, 1'b0, 1'b1, 8'h45, 8'h07, 8'h05},
                 '{3'h2, 8'h03, 1'b0, 1'b0, 8'h45, 8'h05, 8'h05},
                 '{3'h2, 8'h00, 1'b1, 1'b1, 8'h45, 8'h07, 8'h00},
                 '{3'h3, 8'h44, 1'b0, 1'b1, 8'h07, 8'h07, 8'h07},
                 '{3'h4, 8'h44, 1'b0, 1'b0, 8'h43, 8'h07, 8'h03},
                 '{3'h5, 8'h04, 1'b0, 1'b1, 8'h43, 8'h03, 8'h03},
                 '{3'h5, 8'h00, 1'b0, 1'b1, 8'h47, 8'h03, 8'h07},
                 '{3'h6, 8'h04, 1'b0, 1'b0, 8'h43, 8'h03, 8'h03},
                 '{3'h7, 8'h04, 1'b0, 1'b1, 8'h47, 8'h07, 8'h07}};
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            @(negedge ref_clk);
            {mode, dir, gpud, d} = {rows[i].mode, rows[i].dir, rows[i].global_pullup_off, rows[i].d};
            #1;
            chk("out_en_b", rows[i].oeb, oe_b & 8'h47);
            chk("out_val", rows[i].val, o_val & 8'h47);
            chk("pullup_en", rows[i].pu, pu_en & 8'h47);
        end
        chk("toggle_en", 8'h20, to_en);
        @(negedge ref_clk);
        {mode, dir, d, obits} = {3'h1, 8'h00, 1'b1, 8'h06};
        #1;
        chk("dir_ov_val", 8'h02, dd_ov);
        chk("pu_ov_val", 8'h00, pu_ov & 8'h03);
        chk("pullup_en", 8'h00, pu_en & 8'h03);
        chk("din_en", 8'hff, din);
        @(negedge ref_clk);
        obits = 8'h07;
        {mode, dir, gpud, pcg, mask, irq1} = {3'h0, 8'h00, 1'b0, 1'b1, 8'h81, 1'b1};
        #1;
        chk("die_en", 8'h89, die_oe & 8'h8f);
        chk("die_val", 8'h89, die_ov & 8'h8f);
        @(negedge ref_clk);
        {ado, pcg, irq1} = {8'h82, 1'b0, 1'b0};
        #1;
        chk("die_en", 8'h82, die_oe & 8'h8f);
        chk("pin7_ov", 8'h00, (pu_oe | dd_oe | pv_oe) & 8'h80);
        @(negedge ref_clk);
        {ado, ppud} = {8'h00, 2'h1};
        #1;
        chk("pullup_en", 8'h00, pu_en);
        @(negedge ref_clk);
        {ppud, pad} = {2'h2, 8'hff};
        #1;
        chk("pullup_en", 8'h07, pu_en & 8'h07);
        @(negedge ref_clk);
        chk("pin_val", 8'hff, pin_val);
        chk("lin_rx", 8'h01, {7'h00, lrx});
        ado = 8'h01;
        @(negedge ref_clk);
        chk("pin_val", 8'hfe, pin_val);
        chk("lin_rx", 8'h00, {7'h00, lrx});
        {ado, rst_b} = {8'h00, 1'b0};
        @(negedge ref_clk);
        chk("pin_val", 8'h00, pin_val);
        results();
    end
endmodule
